// [sac_host_model.sv]
// Host controller model for the three-wire serial link of the attenuator.
// Assumes the bench calls send_frame; the serial clock stands still between frames.
`timescale 1ns/10ps
module sac_host_model (
  output logic chip_select_n, // Serial select, active low
  output logic serial_clk, // Serial clock, 48 ns period in frames
  output logic serial_data // Serial data
);
  // Idle levels from time zero
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_data = 1'b0;
  end

  // Send n bits MSB first; data moves with the falling edge, so a 48 ns clock
  // period gives 24 ns of setup and of hold around every rising edge
  task automatic send_frame(input logic [63:0] bits, input int n);
    chip_select_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data <= bits[i];
      #24 serial_clk <= 1'b1;
      #24 serial_clk <= 1'b0;
    end
    #24 chip_select_n <= 1'b1;
    // Released data line must not keep showing the last bit
    serial_data <= ~serial_data;
  endtask
endmodule // sac_host_model

// [sac_pkg.sv]
// Shared constants and types for the step attenuator control block.
// Assumes a single 200 MHz system clock; every pin is asynchronous to it.
package sac_pkg;

  // Frame layout
  localparam int SAC_FRAME_BITS = 28; // Data bits per serial frame
  localparam int SAC_WORD_BITS = 5; // Bits in one attenuation word
  localparam int SAC_NUM_PRESETS = 4; // Stored preset words
  localparam int SAC_PRESET1_LSB = 8; // Lowest bit of preset one; bits below are reserved
  localparam int SAC_BITCNT_W = 6; // Width of the frame bit counter

  // Reset values
  localparam logic [4:0] SAC_PRESET_RST = 5'h00; // Presets start at no attenuation
  localparam logic [4:0] SAC_ATTEN_RST = 5'h00; // Applied setting after reset
  localparam logic [10:0] SAC_PINS_RST = 11'h400; // Chip select idles high, rest low

  // Timing
  localparam int SAC_CLK_PERIOD_NS = 5; // System clock period
  localparam int SAC_SWITCH_NS = 25; // Longest pin-to-setting switching time
  localparam int SAC_SWITCH_CYC = SAC_SWITCH_NS / SAC_CLK_PERIOD_NS; // Rounded down

  // Pins sampled from the outside world, kept together so they share one delay
  typedef struct packed {
    logic csn; // Chip select, active low
    logic sclk; // Serial clock
    logic sdi; // Serial data
    logic intf_sel; // 1 = serial presets, 0 = parallel bus
    logic sel_hi; // Upper preset-select pin
    logic sel_lo; // Lower preset-select pin
    logic [4:0] par; // Parallel attenuation bus, bit 0 = 1 dB
  } sac_pins_t;

  // Synchroniser state
  typedef struct packed {
    sac_pins_t ff1; // First stage, read only by the second
    sac_pins_t ff2; // Second stage
    sac_pins_t ff3; // Third stage
    sac_pins_t out; // Filtered, agreed value
  } sac_sync_st_t;

  // Main block state
  typedef struct packed {
    logic [SAC_FRAME_BITS-1:0] shift; // Serial shift register
    logic [SAC_NUM_PRESETS-1:0][SAC_WORD_BITS-1:0] preset; // Holding registers
    logic [SAC_BITCNT_W-1:0] bit_cnt; // Clocks seen in this frame, saturating
    logic sclk_prev; // Last filtered serial clock
    logic csn_prev; // Last filtered chip select
    logic [SAC_WORD_BITS-1:0] atten; // Applied attenuation
    logic serial_mode; // Applied source
    logic frame_done; // One-cycle latch pulse
    logic frame_bad; // Last frame length was not exact
  } sac_state_t;

endpackage

// [sac_step_atten.sv]
// Control logic of a 5-bit, 1 dB step attenuator: 3-wire serial preset
// loading, preset selection pins and a direct parallel bus.
// Assumes every pin is asynchronous to clk; the serial clock is slow
// enough (48 ns period or more) to be sampled and edge-detected here.
//
// Functional notes
// - Frame is 28 bits, MSB first, one select-low.
// - Shift one bit per serial clock rise while selected.
// - Select rising latches presets and updates setting.
// - Interface select 0 parallel, 1 serial presets.
// - Bits 27..23 form preset four, MSB first.
// - Bits 22..18 form preset three.
// - Bits 17..13 form preset two.
// - Bits 12..8 form preset one.
// - Parallel bit high enables its stage; 1..16dB.
// - Parallel changes apply directly, within 25 ns.
// - Lower select toggles pairs; both reach four.
// - Select pins map to presets one through four.
// - Presets written only by serial frames.
// - Preset switching as fast as parallel.
`timescale 1ns/10ps
module sac_step_atten (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic chip_select_n, // Serial chip select pin, active low
  input wire logic serial_clk, // Serial clock pin
  input wire logic serial_data, // Serial data pin
  input wire logic interface_select, // Source pin: 1 serial, 0 parallel
  input wire logic par_atten_1db, // Parallel 1 dB stage enable
  input wire logic par_atten_2db, // Parallel 2 dB stage enable
  input wire logic par_atten_4db, // Parallel 4 dB stage enable
  input wire logic par_atten_8db, // Parallel 8 dB stage enable
  input wire logic par_atten_16db, // Parallel 16 dB stage enable
  input wire logic preset_sel_lo, // Lower preset-select pin
  input wire logic preset_sel_hi, // Upper preset-select pin
  output logic [sac_pkg::SAC_WORD_BITS-1:0] atten_setting, // Applied stages, bit 0 = 1 dB
  output logic serial_mode, // Setting comes from presets
  output logic frame_latched, // One-cycle pulse after a frame latch
  output logic frame_len_err // Last frame had other than 28 clocks
);
  import sac_pkg::*;

  localparam int SWITCH_CYC = SAC_SWITCH_CYC; // Pin-to-setting budget in cycles
  localparam logic [SAC_BITCNT_W-1:0] CNT_MAX = 6'h3F; // Counter saturation
  localparam logic [SAC_BITCNT_W-1:0] CNT_FRAME = 6'h1C; // Exact frame length

  // Pick one preset word out of a frame; index 0 is preset one
  function automatic logic [SAC_WORD_BITS-1:0] preset_field(
    input logic [SAC_FRAME_BITS-1:0] frame,
    input int unsigned idx
  );
    preset_field = frame[SAC_PRESET1_LSB + idx * SAC_WORD_BITS +: SAC_WORD_BITS];
  endfunction

  // Map select pins to a preset index: lower pin is the index LSB
  function automatic logic [1:0] sel_index(input logic hi, input logic lo);
    sel_index = {hi, lo};
  endfunction

  sac_pins_t pins_raw; // Pins gathered for the synchroniser
  sac_pins_t s; // Filtered pins
  sac_state_t q; // Registered state
  sac_state_t n; // Next state
  logic sclk_rise; // Serial clock rising edge seen
  logic cs_rise; // Chip select rising edge seen
  logic [1:0] sel; // Current preset index

  // Gather pins; all share one synchroniser so data stays aligned to clock
  always_comb begin
    pins_raw.csn = chip_select_n;
    pins_raw.sclk = serial_clk;
    pins_raw.sdi = serial_data;
    pins_raw.intf_sel = interface_select;
    pins_raw.sel_hi = preset_sel_hi;
    pins_raw.sel_lo = preset_sel_lo;
    pins_raw.par = {par_atten_16db, par_atten_8db, par_atten_4db, par_atten_2db,
                    par_atten_1db};
  end

  // Pin synchroniser
  sac_sync u_sync (
    .clk(clk),
    .rst(rst),
    .pins_raw(pins_raw),
    .pins_sync(s)
  );

  // Edge detection on filtered pins
  assign sclk_rise = s.sclk & ~q.sclk_prev;
  assign cs_rise = s.csn & ~q.csn_prev;
  assign sel = sel_index(s.sel_hi, s.sel_lo);

  // Next-state logic for shifting, latching and the applied setting
  always_comb begin
    n = q;
    n.sclk_prev = s.sclk;
    n.csn_prev = s.csn;
    n.frame_done = 1'b0;
    // Shift only while selected; a clock edge with select high is ignored
    if (!s.csn && sclk_rise) begin
      n.shift = {q.shift[SAC_FRAME_BITS-2:0], s.sdi};
      if (q.bit_cnt != CNT_MAX) begin
        n.bit_cnt = q.bit_cnt + 6'h01;
      end
    end
    // Latch on select release; shift register depth keeps the last 28 bits
    if (cs_rise) begin
      for (int i = 0; i < SAC_NUM_PRESETS; i++) begin
        // Bits below preset one are never read
        n.preset[i] = preset_field(q.shift, i);
      end
      n.frame_done = 1'b1;
      n.frame_bad = (q.bit_cnt != CNT_FRAME);
      n.bit_cnt = '0;
    end
    // Source choice; new presets apply in the same cycle as the latch
    n.serial_mode = s.intf_sel;
    if (s.intf_sel) begin
      n.atten = n.preset[sel];
    end else begin
      n.atten = s.par;
    end
  end

  // State register; no reset is documented, so presets clear to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q.shift <= '0;
      q.preset <= {SAC_NUM_PRESETS{SAC_PRESET_RST}};
      q.bit_cnt <= '0;
      q.sclk_prev <= 1'b0;
      q.csn_prev <= 1'b1;
      q.atten <= SAC_ATTEN_RST;
      q.serial_mode <= 1'b0;
      q.frame_done <= 1'b0;
      q.frame_bad <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from flip-flops
  assign atten_setting = q.atten;
  assign serial_mode = q.serial_mode;
  assign frame_latched = q.frame_done;
  assign frame_len_err = q.frame_bad;

  // Checks on the serial path, selection and source choice
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_bit_edge;
    !s.csn && sclk_rise;
  endsequence

  sequence seq_latch;
    cs_rise;
  endsequence

  sequence seq_quiet;
    !cs_rise [*2];
  endsequence

  a_shift_on_edge: assert property (seq_bit_edge |=>
    q.shift == {$past(q.shift[SAC_FRAME_BITS-2:0]), $past(s.sdi)})
    else $error("shift register missed a serial bit");

  a_shift_hold_idle: assert property (s.csn && !cs_rise |=> $stable(q.shift))
    else $error("shift register moved while deselected");

  a_latch_top_word: assert property (seq_latch |=>
    q.preset[3] == $past(q.shift[27:23]))
    else $error("preset four not loaded from top bits");

  a_latch_mid_words: assert property (seq_latch |=>
    q.preset[2] == $past(q.shift[22:18]) && q.preset[1] == $past(q.shift[17:13]))
    else $error("presets three or two loaded wrongly");

  a_latch_low_word: assert property (seq_latch |=>
    q.preset[0] == $past(q.shift[12:8]))
    else $error("preset one not loaded from bits 12 to 8");

  a_preset_write_only: assert property (seq_quiet |-> $stable(q.preset))
    else $error("preset changed without a frame latch");

  a_latch_applies: assert property (seq_latch ##0 s.intf_sel |=>
    q.atten == q.preset[$past(sel)] && frame_latched)
    else $error("setting not updated at frame latch");

  a_par_direct: assert property (!s.intf_sel |=> atten_setting == $past(s.par))
    else $error("parallel bus not applied");

  a_par_budget: assert property ($changed(s.par) && !s.intf_sel |->
    ##[1:SWITCH_CYC] atten_setting == $past(s.par))
    else $error("parallel change exceeded switching budget");

  a_sel_follow: assert property (s.intf_sel && !cs_rise |=>
    atten_setting == $past(q.preset[sel]) && serial_mode)
    else $error("serial setting does not follow select pins");

  a_frame_length: assert property (seq_latch ##0 (q.bit_cnt != CNT_FRAME) |=>
    frame_len_err ##1 !frame_latched)
    else $error("bad frame length not flagged");

  // The latch pulse must not stretch, or a user counting frames would miscount
  a_latch_pulse_once: assert property (frame_latched |=> !frame_latched)
    else $error("frame latch pulse longer than one cycle");

  // The source flag is a plain registered copy of the filtered select pin
  a_mode_copy: assert property (1'b1 |=> serial_mode == $past(s.intf_sel))
    else $error("source flag does not follow interface select");

  // An exact frame clears the length flag again
  a_frame_exact: assert property (seq_latch ##0 (q.bit_cnt == CNT_FRAME) |=>
    !frame_len_err)
    else $error("exact frame flagged as bad length");

endmodule // sac_step_atten

// [sac_sync.sv]
// Three-stage synchroniser with agreement filter for all control pins.
// Assumes the pins are quasi-static against clk; a value passes once
// stages two and three agree, so a one-sample glitch is dropped.
`timescale 1ns/10ps
module sac_sync (
  input wire logic clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input sac_pkg::sac_pins_t pins_raw, // Raw pin levels
  output sac_pkg::sac_pins_t pins_sync // Filtered pin levels
);
  import sac_pkg::*;

  sac_sync_st_t q; // Registered state
  sac_sync_st_t d; // Next state

  // Shift the stages; update the output only where stages agree
  always_comb begin
    d = q;
    d.ff1 = pins_raw;
    d.ff2 = q.ff1;
    d.ff3 = q.ff2;
    // Bitwise agreement keeps each pin independent of its neighbours
    d.out = (q.ff2 & ~(q.ff2 ^ q.ff3)) | (q.out & (q.ff2 ^ q.ff3));
  end

  // State register; reset loads constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= {4{SAC_PINS_RST}};
    end else begin
      q <= d;
    end
  end

  assign pins_sync = q.out;

endmodule // sac_sync

// [step_attenuator_control_tb.sv]
// Self-checking bench for the step attenuator control block.
// Assumes sac_host_model drives the serial pins; the bench drives the rest.
`timescale 1ns/10ps
module step_attenuator_control_tb;
  import sac_pkg::*;
  logic clk = 1'b0; // 200 MHz system clock
  logic rst = 1'b1; // Reset, active high
  logic interface_select = 1'b0; // Source select
  logic [4:0] par = 5'h00; // Parallel bus, bit 0 = 1 dB
  logic sel_lo = 1'b0; // Lower preset select
  logic sel_hi = 1'b0; // Upper preset select
  logic chip_select_n, sclk, sdi; // Serial pins from the host
  logic [4:0] atten; // Applied setting
  logic smode, latched, len_err; // Status outputs
  logic [4:0] pr [4]; // Expected presets, index {hi,lo}
  int errors = 0; // Mismatch count
  int n_checks = 0; // Comparison count

  always #2.5 clk = ~clk;

  sac_host_model host (.chip_select_n(chip_select_n), .serial_clk(sclk), .serial_data(sdi));

  sac_step_atten dut (
    .clk(clk), .rst(rst), .chip_select_n(chip_select_n), .serial_clk(sclk),
    .serial_data(sdi), .interface_select(interface_select),
    .par_atten_1db(par[0]), .par_atten_2db(par[1]), .par_atten_4db(par[2]),
    .par_atten_8db(par[3]), .par_atten_16db(par[4]),
    .preset_sel_lo(sel_lo), .preset_sel_hi(sel_hi), .atten_setting(atten),
    .serial_mode(smode), .frame_latched(latched), .frame_len_err(len_err)
  );

  // Compare one value; four-state compare so an unknown matches only the same unknown
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Drive the level pins, then wait the five-cycle path to the setting
  task automatic set_pins(input logic m, input logic [4:0] p, input logic [1:0] s);
    @(posedge clk);
    interface_select <= m;
    par <= p;
    {sel_hi, sel_lo} <= s;
    repeat (5) @(posedge clk);
    #1;
  endtask

  // Send a frame and wait, bounded, for the latch pulse
  task automatic load(input logic [63:0] bits, input int n);
    int k;
    host.send_frame(bits, n);
    k = 0;
    while (latched !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    check(k < 40, 1'b1);
    check(atten, pr[{sel_hi, sel_lo}]);
  endtask

  // Each stage alone, then all stages; select pins must not matter here
  task automatic t_parallel;
    logic [4:0] v;
    for (int i = 0; i < 6; i++) begin
      v = (i < 5) ? (5'h01 << i) : 5'h1F;
      set_pins(1'b0, v, 2'h3);
      check(atten, v);
      check(smode, 1'b0);
    end
  endtask

  // Walk all four presets through the select pins
  task automatic walk_presets;
    for (int s = 0; s < 4; s++) begin
      set_pins(1'b1, 5'h00, s[1:0]);
      check(atten, pr[s]);
      check(smode, 1'b1);
    end
  endtask

  // Exact frame, then preset switching by pins only
  task automatic t_serial;
    pr[0] = 5'h03;
    pr[1] = 5'h1F;
    pr[2] = 5'h0A;
    pr[3] = 5'h15;
    set_pins(1'b1, 5'h00, 2'h0);
    load({36'h0, pr[3], pr[2], pr[1], pr[0], 8'h00}, 28);
    check(len_err, 1'b0);
    walk_presets();
  endtask

  // Overlong frame keeps the last bits; parallel use leaves preset four intact
  task automatic t_long;
    pr[0] = 5'h11;
    pr[1] = 5'h06;
    pr[2] = 5'h1C;
    pr[3] = 5'h09;
    load({34'h0, 2'h3, pr[3], pr[2], pr[1], pr[0], 8'h00}, 30);
    check(len_err, 1'b1);
    walk_presets();
    set_pins(1'b0, 5'h0B, 2'h0);
    check(atten, 5'h0B);
    set_pins(1'b1, 5'h00, 2'h3);
    check(atten, pr[3]);
  endtask

  // Print counts and verdict, then stop
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    t_parallel();
    t_serial();
    t_long();
    finish_test();
  end

  // Watchdog, well beyond the few microseconds the tests need
  initial begin
    #200000;
    errors++;
    finish_test();
  end
endmodule // step_attenuator_control_tb
